/* File: sram_port_consts.vh */
// constants for the pipelined burst sram port
`ifndef SRAM_PORT_CONSTS_VH
`define SRAM_PORT_CONSTS_VH
`define ADDR_W      17
`define DATA_W      32
`define LANES       4
`define LANE_W      9
`define BYTE_W      8
`define WORD_W      36
`define MEM_WORDS   131072
`define BEAT_W      2
`define PIN_W       65
`define FIFO_DEPTH  32
`define FIFO_AW     5
`define FIFO_W      57
`define BEAT_FIRST  2'h0
`define BEAT_STEP   2'h1
`define SEL_DESEL   1'b0
`endif

/* File: pipelined_burst_sram_port.v */
// pipelined burst sram port: write buffer fifo and device logic
`timescale 1ns/1ps
`include "sram_port_consts.vh"

// Summary of operation
// [R1] held clock edge leaves all state unchanged; the two pin capture registers still load on held edges
// [R2] inputs registered, read data from output register
// [R3] load with selects, write high starts read
// [R4] read data drives one edge after address
// [R5] drivers on only with output enable low
// [R6] new command accepted every clock
// [R7] deselect floats outputs after next edge
// [R8] burst counter gives four beats per address
// [R9] order input low linear, high interleaved
// [R10] burst changes only two low address bits
// [R11] step edge advances, ignores selects and strobe
// [R12] direction latched at load, kept through burst
// [R13] load with selects, strobe low starts write
// [R14] edge after write releases bus always
// [R15] write data taken two edges after command
// [R16] only selected byte lanes are written
// [R17] host keeps off bus while device drives
// [R18] host gives lane selects on every beat
// [R19] interleaved beat equals start xor index
// [R20] host loads fresh address after deselect
// [R21] linear beat equals start plus index
// [R22] outputs float on first clock after deselect
// [R23] comes up deselected with bus floating
// [R24] parity bit follows its own lane select
// [R25] array holds 131072 words of 36 bits

// ==========================================================
// write buffer fifo
module sram_write_fifo #(
    parameter WIDTH = `FIFO_W,
    parameter DEPTH = `FIFO_DEPTH,
    parameter AW    = `FIFO_AW
) (
    input  wire             clk,
    input  wire             reset_n,
    input  wire             inValid,
    output wire             inReady,
    input  wire [WIDTH-1:0] inData,
    output wire             outValid,
    input  wire             outReady,
    output wire [WIDTH-1:0] outData
);
    localparam [AW:0] FULL_COUNT = DEPTH;
    localparam [AW:0] ONE_COUNT  = 1;
    localparam [AW-1:0] ONE_PTR  = 1;

    reg [WIDTH-1:0] store [0:DEPTH-1];
    reg [AW-1:0]    wrPtr_reg;
    reg [AW-1:0]    rdPtr_reg;
    reg [AW:0]      count_reg;
    wire            doPush;
    wire            doPop;

    assign inReady  = (count_reg != FULL_COUNT);
    assign outValid = (count_reg != {(AW+1){1'b0}});
    assign outData  = store[rdPtr_reg];
    assign doPush   = inValid & inReady;
    assign doPop    = outValid & outReady;

    always @(posedge clk) begin
        if (doPush) begin
            store[wrPtr_reg] <= inData;
        end
    end

    always @(posedge clk) begin
        if (!reset_n) begin
            wrPtr_reg <= {AW{1'b0}};
            rdPtr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
        end else begin
            if (doPush) begin
                wrPtr_reg <= wrPtr_reg + ONE_PTR;
            end
            if (doPop) begin
                rdPtr_reg <= rdPtr_reg + ONE_PTR;
            end
            if (doPush && !doPop) begin
                count_reg <= count_reg + ONE_COUNT;
            end else if (doPop && !doPush) begin
                count_reg <= count_reg - ONE_COUNT;
            end
        end
    end
endmodule // sram_write_fifo

// ==========================================================
// device top
module pipelined_burst_sram_port (
    input  wire                 clk,
    input  wire                 reset_n,
    input  wire [`ADDR_W-1:0]   addr,
    input  wire                 chip_sel_a_n,
    input  wire                 chip_sel_b,
    input  wire                 chip_sel_c_n,
    input  wire                 wr_strobe_n,
    input  wire                 step_or_capture_n,
    input  wire [`LANES-1:0]    lane_write_sel_n,
    input  wire                 clk_hold_n,
    input  wire                 out_drive_en_n,
    input  wire                 burst_order,
    input  wire [`DATA_W-1:0]   dqIn,
    output wire [`DATA_W-1:0]   dqOut,
    output wire [`DATA_W-1:0]   dqOe,
    input  wire [`LANES-1:0]    parityIn,
    output wire [`LANES-1:0]    parityOut,
    output wire [`LANES-1:0]    parityOe
);
    // ======================================================
    // pin capture
    reg  [`PIN_W-1:0]  pinS1_reg;
    reg  [`PIN_W-1:0]  pinS2_reg;
    wire [`PIN_W-1:0]  pinIn;

    assign pinIn = {burst_order, out_drive_en_n, clk_hold_n, step_or_capture_n,
                    wr_strobe_n, chip_sel_c_n, chip_sel_b, chip_sel_a_n,
                    lane_write_sel_n, addr, parityIn, dqIn};

    // pins run free of the hold: the release itself must be seen
    always @(posedge clk) begin
        if (!reset_n) begin
            pinS1_reg <= {`PIN_W{1'b0}};
            pinS2_reg <= {`PIN_W{1'b0}};
        end else begin
            pinS1_reg <= pinIn; // [R2]
            pinS2_reg <= pinS1_reg;
        end
    end

    wire               orderS  = pinS2_reg[64];
    wire               oeNS    = pinS2_reg[63];
    wire               holdNS  = pinS2_reg[62];
    wire               stepS   = pinS2_reg[61];
    wire               wrNS    = pinS2_reg[60];
    wire               csCNS   = pinS2_reg[59];
    wire               csBS    = pinS2_reg[58];
    wire               csANS   = pinS2_reg[57];
    wire [`LANES-1:0]  lanesNS = pinS2_reg[56:53];
    wire [`ADDR_W-1:0] addrS   = pinS2_reg[52:36];
    wire [`LANES-1:0]  parS    = pinS2_reg[35:32];
    wire [`DATA_W-1:0] dqS     = pinS2_reg[31:0];

    // ======================================================
    // qualified edge and command decode
    wire fifoInReady;
    wire fifoOutValid;
    wire [`FIFO_W-1:0] fifoOut;
    wire qual;
    wire selAll;
    wire startOp;
    wire burstOp;
    reg  busy_reg;

    // a full write buffer stretches the cycle just like a hold
    assign qual    = ~holdNS & fifoInReady; // [R1]
    assign selAll  = ~csANS & csBS & ~csCNS;
    assign startOp = ~stepS & selAll; // [R3] [R13]
    assign burstOp = stepS & busy_reg; // [R11]

    reg                dirWr_reg;
    reg [`ADDR_W-1:0]  base_reg;
    reg [`BEAT_W-1:0]  beat_reg;
    wire [`BEAT_W-1:0] beatNext;
    wire [`BEAT_W-1:0] lowNext;

    assign beatNext = beat_reg + `BEAT_STEP;
    assign lowNext  = orderS ? (base_reg[1:0] ^ beatNext) // [R9] [R19]
                             : (base_reg[1:0] + beatNext); // [R21]

    always @(posedge clk) begin
        if (!reset_n) begin
            busy_reg  <= `SEL_DESEL; // [R23]
            dirWr_reg <= 1'b0;
            base_reg  <= {`ADDR_W{1'b0}};
            beat_reg  <= `BEAT_FIRST;
        end else if (qual) begin
            if (!stepS) begin
                busy_reg <= selAll; // [R7]
                if (selAll) begin
                    base_reg  <= addrS;
                    dirWr_reg <= ~wrNS; // [R12]
                    beat_reg  <= `BEAT_FIRST;
                end
            end else if (busy_reg) begin
                // counter wraps within the group of four
                beat_reg <= beatNext; // [R8]
            end
        end
    end

    // ======================================================
    // pipeline: address stage, data stage
    reg                p1Valid_reg;
    reg                p1Wr_reg;
    reg [`ADDR_W-1:0]  p1Addr_reg;
    reg [`LANES-1:0]   p1Lanes_reg;
    reg                p2Wr_reg;
    reg [`ADDR_W-1:0]  p2Addr_reg;
    reg [`LANES-1:0]   p2Lanes_reg;
    reg                outActive_reg;
    reg [`WORD_W-1:0]  dout_reg;
    wire               p1Rd;

    assign p1Rd = p1Valid_reg & ~p1Wr_reg;

    // storage array
    reg  [`WORD_W-1:0] mem [0:`MEM_WORDS-1]; // [R25]

    always @(posedge clk) begin
        if (!reset_n) begin
            p1Valid_reg   <= 1'b0;
            p1Wr_reg      <= 1'b0;
            p1Addr_reg    <= {`ADDR_W{1'b0}};
            p1Lanes_reg   <= {`LANES{1'b1}};
            p2Wr_reg      <= 1'b0;
            p2Addr_reg    <= {`ADDR_W{1'b0}};
            p2Lanes_reg   <= {`LANES{1'b1}};
            outActive_reg <= 1'b0; // [R23]
            dout_reg      <= {`WORD_W{1'b0}};
        end else if (qual) begin
            p1Valid_reg <= startOp | burstOp; // [R6]
            p1Wr_reg    <= startOp ? ~wrNS : dirWr_reg; // [R12]
            p1Addr_reg  <= startOp ? addrS
                                   : {base_reg[`ADDR_W-1:2], lowNext}; // [R10]
            p1Lanes_reg <= lanesNS; // [R18]
            dout_reg    <= mem[p1Addr_reg]; // [R2] [R4]
            // write beats, deselects and first clock out of deselect float
            outActive_reg <= p1Rd; // [R7] [R14] [R22]
            p2Wr_reg    <= p1Valid_reg & p1Wr_reg;
            p2Addr_reg  <= p1Addr_reg;
            p2Lanes_reg <= p1Lanes_reg;
        end
    end

    // ======================================================
    // lane packing and output drive
    wire [`WORD_W-1:0] wordIn;
    wire [`WORD_W-1:0] drainOld;
    wire [`WORD_W-1:0] drainMerged;
    wire [`ADDR_W-1:0] drainAddr  = fifoOut[`FIFO_W-1:`FIFO_W-`ADDR_W];
    wire [`LANES-1:0]  drainLanes = fifoOut[`WORD_W+`LANES-1:`WORD_W];
    wire [`WORD_W-1:0] drainData  = fifoOut[`WORD_W-1:0];
    wire               drive;

    assign drainOld = mem[drainAddr];
    assign drive    = outActive_reg & ~oeNS; // [R5]

    genvar i;
    generate
        for (i = 0; i < `LANES; i = i + 1) begin : laneGen
            assign wordIn[i*`LANE_W +: `LANE_W] =
                {parS[i], dqS[i*`BYTE_W +: `BYTE_W]}; // [R24]
            assign drainMerged[i*`LANE_W +: `LANE_W] = drainLanes[i]
                ? drainOld[i*`LANE_W +: `LANE_W]
                : drainData[i*`LANE_W +: `LANE_W]; // [R16] [R24]
            assign dqOut[i*`BYTE_W +: `BYTE_W] =
                dout_reg[i*`LANE_W +: `BYTE_W];
            assign parityOut[i] = dout_reg[i*`LANE_W + `BYTE_W];
            assign dqOe[i*`BYTE_W +: `BYTE_W] = {`BYTE_W{drive}}; // [R14]
            assign parityOe[i] = drive;
        end
    endgenerate

    // ======================================================
    // write buffer and array update
    wire fifoPush;
    wire fifoDrain;

    // data is on the bus two qualified edges after the command
    assign fifoPush = qual & p2Wr_reg; // [R15]
    // one array port: a pending read fetch wins over a drain,
    // unless the buffer is full and would otherwise lock up
    assign fifoDrain = ~holdNS & (~p1Rd | ~fifoInReady); // [R1]

    sram_write_fifo #(
        .WIDTH (`FIFO_W),
        .DEPTH (`FIFO_DEPTH),
        .AW    (`FIFO_AW)
    ) writeBuf (
        .clk      (clk),
        .reset_n  (reset_n),
        .inValid  (fifoPush),
        .inReady  (fifoInReady),
        .inData   ({p2Addr_reg, p2Lanes_reg, wordIn}),
        .outValid (fifoOutValid),
        .outReady (fifoDrain),
        .outData  (fifoOut)
    );

    always @(posedge clk) begin
        if (fifoOutValid && fifoDrain) begin
            mem[drainAddr] <= drainMerged; // [R16]
        end
    end
endmodule // pipelined_burst_sram_port

/* File: host_bus_model.sv */
// host side model of the shared data and parity bus
`timescale 1ns/1ps
module host_bus_model (
    input  wire         clk,
    input  wire         devOe,
    input  wire  [35:0] devWord,
    input  wire         hostDrive,
    input  wire  [35:0] hostWord,
    output logic [35:0] busWord
);
    // ==========================================
    // bus resolution
    logic [35:0] lastBus = 36'h0;
    // released bus shows the inverse of its last value, so it flips every clock while nobody drives it
    always_comb begin
        busWord = ~lastBus;
        if (hostDrive) busWord = hostWord;
        if (devOe) busWord = devWord;
    end
    always @(posedge clk) lastBus <= busWord;
endmodule // host_bus_model

/* File: sram_port_checker_sva.sv */
// concurrent checks on the sram port pins
`timescale 1ns/1ps
module sram_port_checker (
    input wire        clk,
    input wire        reset_n,
    input wire        chip_sel_a_n,
    input wire        chip_sel_b,
    input wire        chip_sel_c_n,
    input wire        wr_strobe_n,
    input wire        step_or_capture_n,
    input wire        clk_hold_n,
    input wire        out_drive_en_n,
    input wire [31:0] dqOut,
    input wire [31:0] dqOe,
    input wire [3:0]  parityOut,
    input wire [3:0]  parityOe
);
    // ==========================================
    // sequences
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    wire allSel = !chip_sel_a_n && chip_sel_b && !chip_sel_c_n;
    sequence loadCmd; !clk_hold_n && !step_or_capture_n; endsequence
    // pins pass two sync flops, so results land four samples later
    sequence run4; (!clk_hold_n)[*4]; endsequence
    // ==========================================
    // assertions
    oe_lanes_same_a: assert property (dqOe == {32{dqOe[0]}} && parityOe == {4{dqOe[0]}})
        else $error("lane enables differ");
    oe_needs_enable_a: assert property (dqOe[0] |-> !$past(out_drive_en_n, 2))
        else $error("driving without enable");
    reset_floats_a: assert property (disable iff (1'b0) !reset_n |=> dqOe == 32'h0)
        else $error("bus driven in reset");
    wake_quiet_a: assert property ($rose(reset_n) |-> (!dqOe[0])[*3])
        else $error("bus driven after reset");
    write_floats_a: assert property (loadCmd ##0 (allSel && !wr_strobe_n) ##1 run4 |-> !dqOe[0])
        else $error("bus driven on write");
    read_drives_a: assert property (loadCmd ##0 (allSel && wr_strobe_n) ##1
        (!clk_hold_n && !out_drive_en_n)[*4] |-> dqOe[0]) else $error("read data missing");
    desel_floats_a: assert property (loadCmd ##0 !allSel ##1 run4 |-> !dqOe[0])
        else $error("bus driven when deselected");
    hold_freezes_a: assert property (clk_hold_n |-> ##3 $stable(dqOut) && $stable(parityOut))
        else $error("held edge changed output");
endmodule // sram_port_checker
bind pipelined_burst_sram_port sram_port_checker chk_u (.clk(clk), .reset_n(reset_n),
    .chip_sel_a_n(chip_sel_a_n), .chip_sel_b(chip_sel_b), .chip_sel_c_n(chip_sel_c_n),
    .wr_strobe_n(wr_strobe_n), .step_or_capture_n(step_or_capture_n),
    .clk_hold_n(clk_hold_n), .out_drive_en_n(out_drive_en_n), .dqOut(dqOut), .dqOe(dqOe),
    .parityOut(parityOut), .parityOe(parityOe));

/* File: tb_pipelined_burst_sram_port.sv */
// testbench for the pipelined burst sram port
`timescale 1ns/1ps
module tb_pipelined_burst_sram_port;
    // ==========================================
    // signals
    logic        clk = 1'b0, reset_n = 1'b0, csN = 1'b1, wrN = 1'b1, stepN = 1'b0;
    logic        holdN = 1'b0, order = 1'b0, hDrv = 1'b0, oeN = 1'b0;
    logic [16:0] addr = 17'h0;
    logic [3:0]  laneN = 4'hf;
    logic [35:0] hWord = 36'h0;
    wire  [35:0] bus;
    wire  [31:0] dqOut, dqOe;
    wire  [3:0]  pOut, pOe;
    logic [35:0] model [logic [16:0]];
    int          errTotal = 0, numChecks = 0;
    always #4 clk = ~clk;
    pipelined_burst_sram_port dut_u (.clk(clk), .reset_n(reset_n), .addr(addr),
        .chip_sel_a_n(csN), .chip_sel_b(~csN), .chip_sel_c_n(csN), .wr_strobe_n(wrN),
        .step_or_capture_n(stepN), .lane_write_sel_n(laneN), .clk_hold_n(holdN),
        .out_drive_en_n(oeN), .burst_order(order), .dqIn(bus[31:0]), .dqOut(dqOut),
        .dqOe(dqOe), .parityIn(bus[35:32]), .parityOut(pOut), .parityOe(pOe));
    host_bus_model host_u (.clk(clk), .devOe(dqOe[0]), .devWord({pOut, dqOut}),
        .hostDrive(hDrv), .hostWord(hWord), .busWord(bus));
    // ==========================================
    // helpers
    function automatic logic [16:0] nth(input logic [16:0] a, input int k);
        return {a[16:2], order ? a[1:0] ^ 2'(k) : a[1:0] + 2'(k)};
    endfunction
    function automatic logic [35:0] pat(input logic [16:0] b);
        return {b[3:0], b[15:0], ~b[15:0]};
    endfunction
    task automatic check(input logic [35:0] got, input logic [35:0] want);
        numChecks++;
        if (got !== want) begin
            errTotal++;
            $display("BAD t=%0t got=%h want=%h", $time, got, want);
        end
    endtask
    task automatic pins(input logic [16:0] a, input logic s, w, st, input logic [3:0] ln);
        addr <= a;
        csN <= ~s;
        wrN <= w;
        stepN <= st;
        laneN <= ln;
    endtask
    // data two clocks behind the command; steps carry junk selects and strobe
    task automatic wr_burst(input logic [16:0] a, input logic [3:0] ln, input int n,
                            input logic [35:0] x);
        logic [16:0] b;
        logic [35:0] w;
        for (int i = 0; i < n + 3; i++) begin
            @(posedge clk);
            if (i == 0) pins(a, 1'b1, 1'b0, 1'b0, ln);
            else if (i < n) pins(~a, 1'b0, 1'b1, 1'b1, ln);
            else pins(a, 1'b0, 1'b1, 1'b0, 4'hf);
            hDrv <= (i >= 2 && i < n + 2);
            if (i >= 2 && i < n + 2) begin
                b = nth(a, i - 2);
                w = pat(b) ^ x;
                hWord <= w;
                if (!model.exists(b)) model[b] = 36'h0;
                for (int j = 0; j < 4; j++) if (!ln[j]) begin
                    model[b][8*j+:8] = w[8*j+:8];
                    model[b][32+j] = w[32+j];
                end
            end
        end
    endtask
    task automatic rd_burst(input logic [16:0] a);
        for (int i = 0; i < 5; i++) begin
            @(posedge clk);
            if (i == 0) pins(a, 1'b1, 1'b1, 1'b0, 4'hf);
            else if (i < 4) pins(~a, 1'b0, 1'b0, 1'b1, 4'h0);
            else pins(a, 1'b0, 1'b1, 1'b0, 4'hf);
            if (i == 3) #1 check({dqOe, pOe}, 36'h0);
        end
        #1;
        for (int k = 0; k < 4; k++) begin
            check({pOut, dqOut}, model[nth(a, k)]);
            check({dqOe, pOe}, 36'hf_ffff_ffff);
            @(posedge clk) #1;
        end
        check({dqOe, pOe}, 36'h0);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", numChecks, errTotal);
        if (errTotal == 0 && numChecks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // ==========================================
    // scenarios
    task automatic t_reset();
        @(posedge clk) #1;
        check({dqOe, pOe}, 36'h0);
        $display("reset test done");
    endtask
    task automatic t_linear();
        wr_burst(17'h00101, 4'h0, 4, 36'h0);
        wr_burst(17'h1fffd, 4'h0, 4, 36'h0);
        repeat (8) @(posedge clk);
        rd_burst(17'h00101);
        rd_burst(17'h1fffd);
        $display("linear test done");
    endtask
    task automatic t_interleave();
        @(posedge clk);
        order <= 1'b1;
        repeat (2) @(posedge clk);
        rd_burst(17'h00101);
        wr_burst(17'h0a0b2, 4'h0, 4, 36'h0);
        repeat (8) @(posedge clk);
        rd_burst(17'h0a0b2);
        $display("interleave test done");
    endtask
    task automatic t_lanes();
        @(posedge clk);
        holdN <= 1'b1;
        repeat (3) @(posedge clk);
        holdN <= 1'b0;
        wr_burst(17'h00102, 4'b1010, 1, 36'hf_ffff_ffff);
        repeat (8) @(posedge clk);
        rd_burst(17'h00100);
        $display("lane test done");
    endtask
    // enable high: data still registered, drivers stay off
    task automatic t_oe();
        @(posedge clk);
        oeN <= 1'b1;
        pins(17'h00103, 1'b1, 1'b1, 1'b0, 4'hf);
        @(posedge clk);
        pins(17'h00103, 1'b0, 1'b1, 1'b0, 4'hf);
        repeat (3) @(posedge clk);
        #1;
        check({dqOe, pOe}, 36'h0);
        check({pOut, dqOut}, model[17'h00103]);
        @(posedge clk);
        oeN <= 1'b0;
        $display("enable test done");
    endtask
    // hold lands in mid burst, so the held edges would move the pipeline
    task automatic t_hold();
        @(posedge clk);
        pins(17'h00101, 1'b1, 1'b1, 1'b0, 4'hf);
        @(posedge clk);
        pins(17'h1fefe, 1'b0, 1'b0, 1'b1, 4'h0);
        holdN <= 1'b1;
        repeat (2) @(posedge clk);
        holdN <= 1'b0;
        @(posedge clk);
        pins(17'h00101, 1'b0, 1'b1, 1'b0, 4'hf);
        @(posedge clk) #1;
        check({dqOe, pOe}, 36'h0);
        for (int k = 0; k < 2; k++) begin
            @(posedge clk) #1;
            check({pOut, dqOut}, model[nth(17'h00101, k)]);
            check({dqOe, pOe}, 36'hf_ffff_ffff);
        end
        @(posedge clk) #1;
        check({dqOe, pOe}, 36'h0);
        $display("hold test done");
    endtask
    // ==========================================
    // run
    initial begin
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        t_reset();
        t_linear();
        t_interleave();
        t_lanes();
        t_oe();
        t_hold();
        wrap_up();
    end
    // whole run is about 120 cycles
    initial begin
        #40000;
        errTotal++;
        wrap_up();
    end
endmodule // tb_pipelined_burst_sram_port
